// ===== indicator_pkg.sv
// constants shared by the status-indicator controller files
// assumes a single 40 MHz clock and byte addresses on a 32-bit wishbone bus
package indicator_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CNT_W = 26;

    // times in milliseconds and their cycle counts
    localparam int unsigned NO_TARGET_MS = 1000;
    localparam int unsigned NO_TARGET_CYCLES = CLK_HZ / 1000 * NO_TARGET_MS;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / 1000 * SLOW_HALF_MS;
    localparam int unsigned FAST_HALF_MS = 100;
    localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / 1000 * FAST_HALF_MS;
    localparam int unsigned FLICKER_MS = 50;
    localparam int unsigned FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ASSIGN_OFS = 8'h04;
    localparam logic [7:0] NOTGT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] SETUP_OFS = 8'h10;

    // field positions
    localparam int unsigned CTRL_UNLOCK = 0;
    localparam int unsigned CTRL_ALT = 1;
    localparam int unsigned CTRL_SETUP_DIS = 2;
    localparam int unsigned CTRL_ROLE_LO = 3;
    localparam int unsigned CTRL_BTN_RESYNC = 5;
    localparam int unsigned NOTGT_HOLD = 0;
    localparam int unsigned NOTGT_SW_OFF = 1;

    // indicator assignment codes
    localparam logic [2:0] SEL_OFF = 3'h0;
    localparam logic [2:0] SEL_ANALOG = 3'h1;
    localparam logic [2:0] SEL_SWITCH = 3'h2;
    localparam logic [2:0] SEL_RX = 3'h3;
    localparam logic [2:0] SEL_TX = 3'h4;

    // synchronisation roles
    localparam logic [1:0] ROLE_NONE = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE = 2'h2;

    // values after reset
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [2:0] SQUARE_RST = SEL_ANALOG;
    localparam logic [2:0] RECT_RST = SEL_TX;
    localparam logic [1:0] NOTGT_RST = 2'h3;

    // double blink: two short pulses then a gap
    localparam logic [7:0] DBL_PATTERN = 8'h05;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_NEAR = 3'b001,
        MODE_UNLOCK = 3'b011,
        MODE_BUTTON = 3'b010,
        MODE_NOSYNC = 3'b110
    } tgt_mode_e;
endpackage

// ===== blink_if.sv
// blink phases passed from the rate generator to the indicator logic
// assumes one clock for producer and consumers
`timescale 1ns/1ps
interface blink_if;
    logic slow;
    logic fast;
    logic dbl;
    logic slow_tick;
    modport gen (output slow, output fast, output dbl, output slow_tick);
    modport use_side (input slow, input fast, input dbl, input slow_tick);
endinterface

// ===== blink_gen.sv
// free-running slow, fast and double-blink phase generator
// assumes the clock runs continuously after reset
`timescale 1ns/1ps
module blink_gen #(
    parameter int unsigned SLOW_HALF = indicator_pkg::SLOW_HALF_CYCLES,
    parameter int unsigned FAST_HALF = indicator_pkg::FAST_HALF_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // phases
    blink_if.gen bl
);
    logic [indicator_pkg::CNT_W-1:0] slow_cnt_ff;
    logic [indicator_pkg::CNT_W-1:0] fast_cnt_ff;
    logic slow_ff;
    logic fast_ff;
    logic tick_ff;
    logic [2:0] slot_ff;
    logic slow_wrap;
    logic fast_wrap;

    assign slow_wrap = slow_cnt_ff == indicator_pkg::CNT_W'(SLOW_HALF - 1);
    assign fast_wrap = fast_cnt_ff == indicator_pkg::CNT_W'(FAST_HALF - 1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slow_cnt_ff <= '0;
            slow_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            slow_cnt_ff <= slow_wrap ? '0 : slow_cnt_ff + 1'b1;
            slow_ff <= slow_wrap ? ~slow_ff : slow_ff;
            tick_ff <= slow_wrap & ~slow_ff;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fast_cnt_ff <= '0;
            fast_ff <= 1'b0;
            slot_ff <= 3'h0;
        end else begin
            fast_cnt_ff <= fast_wrap ? '0 : fast_cnt_ff + 1'b1;
            fast_ff <= fast_wrap ? ~fast_ff : fast_ff;
            slot_ff <= fast_wrap ? slot_ff + 3'h1 : slot_ff;
        end
    end

    assign bl.slow = slow_ff;
    assign bl.fast = fast_ff;
    assign bl.dbl = indicator_pkg::DBL_PATTERN[slot_ff];
    assign bl.slow_tick = tick_ff;
endmodule

// ===== status_lamp.sv
// one assignable output status indicator, lamp level is combinational
// assumes rx and tx events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module status_lamp #(
    parameter int unsigned FLICKER = indicator_pkg::FLICKER_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // assignment
    input wire logic [2:0] sel,
    // sources
    input wire logic ana_low,
    input wire logic ana_high,
    input wire logic sw_on,
    input wire logic sw_fault,
    input wire logic rx_pulse,
    input wire logic tx_pulse,
    blink_if.use_side bl,
    // lamp
    output logic lamp
);
    logic [indicator_pkg::CNT_W-1:0] flick_ff;
    logic event_hit;

    // pick the event kind that this lamp follows
    assign event_hit = (sel == indicator_pkg::SEL_RX && rx_pulse) || (sel == indicator_pkg::SEL_TX && tx_pulse);

    // stretch a pulse into a visible flash
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flick_ff <= '0;
        end else if (event_hit) begin
            flick_ff <= indicator_pkg::CNT_W'(FLICKER);
        end else if (flick_ff != '0) begin
            flick_ff <= flick_ff - 1'b1;
        end
    end

    always_comb begin
        lamp = 1'b0;
        case (sel)
            // high end wins, low end dark
            indicator_pkg::SEL_ANALOG: lamp = ana_high ? bl.fast : ~ana_low;
            indicator_pkg::SEL_SWITCH: lamp = sw_fault ? bl.slow : sw_on;
            indicator_pkg::SEL_RX,
            indicator_pkg::SEL_TX: lamp = flick_ff != '0;
            default: lamp = 1'b0;
        endcase
    end
endmodule

// ===== indicator_ctrl.sv
// top of the sensor status-indicator controller with a wishbone register slave
// assumes measurement, switch and button levels arrive from pins; serial events are same-clock pulses
`timescale 1ns/1ps
// Function
// - target lamp always red or green; the code leaves it dark in the off-phase of every blink except the no-sync red/green alternation
// - green when target in range
// - red when no target in range
// - fast green flash near minimum range
// - unlocked keeps colour, blinks slowly
// - alternate setup unlocked uses double blink
// - filters disabled while unlocked
// - held button blinks red unless suppressed
// - count flashes, release selects setup function
// - alternate setup hold gives double blink
// - slave without sync alternates red/green
// - each status lamp assignable to source
// - square follows switch one, rectangle two
// - switch lamp lit while conducting
// - switch lamp blinks during protective shutdown
// - fault forces switch off, auto resumes
// - same indication sinking or sourcing
// - analog lamp on, off or blinking
// - one analog status for both outputs
// - rx flashes any data, tx responses
// - streaming transmissions also flash tx
// - no target holds analog, switches off later
module indicator_ctrl #(
    parameter int unsigned NO_TARGET = indicator_pkg::NO_TARGET_CYCLES,
    parameter int unsigned SLOW_HALF = indicator_pkg::SLOW_HALF_CYCLES,
    parameter int unsigned FAST_HALF = indicator_pkg::FAST_HALF_CYCLES,
    parameter int unsigned FLICKER = indicator_pkg::FLICKER_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // measurement pins
    input wire logic target_present,
    input wire logic near_min,
    input wire logic ana_at_low,
    input wire logic ana_at_high,
    // switch pins
    input wire logic sw1_demand,
    input wire logic sw2_demand,
    input wire logic sw1_fault,
    input wire logic sw2_fault,
    // setup button and sync pins
    input wire logic button_pressed,
    input wire logic sync_seen,
    // serial events, same clock
    input wire logic rx_event,
    input wire logic tx_reply_event,
    input wire logic tx_stream_event,
    // indicators
    output logic tgt_red,
    output logic tgt_green,
    output logic square_lamp,
    output logic rect_lamp,
    // outputs to the rest of the sensor
    output logic sw1_out,
    output logic sw2_out,
    output logic analog_hold,
    output logic filters_enable,
    output logic measure_enable,
    output logic [3:0] setup_select,
    output logic setup_strobe
);
    localparam int unsigned NPIN = 10;

    blink_if bl ();

    logic [NPIN-1:0] pin_meta_ff;
    logic [NPIN-1:0] pin_ff;
    logic tgt_s, near_s, low_s, high_s, dem1_s, dem2_s, flt1_s, flt2_s, btn_s, sync_s;
    logic btn_d_ff;

    logic [5:0] ctrl_ff;
    logic [2:0] square_sel_ff;
    logic [2:0] rect_sel_ff;
    logic [1:0] notgt_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;

    logic [indicator_pkg::CNT_W-1:0] notgt_cnt_ff;
    logic notgt_timeout_ff;
    logic resync_skip_ff;
    logic [3:0] flash_cnt_ff;
    logic [3:0] select_ff;
    logic strobe_ff;
    logic red_ff, green_ff, sq_ff, rect_ff;
    logic sw1_ff, sw2_ff, hold_ff, filt_ff, meas_ff;
    indicator_pkg::tgt_mode_e mode;

    logic unlock, alt_mode, setup_dis, btn_resync, nosync, feedback_on;
    logic [1:0] role;
    logic sw1_next, sw2_next, sq_next, rect_next, tx_any;
    logic bus_req, wr_en;

    // two-stage capture of every pin level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta_ff <= '0;
            pin_ff <= '0;
        end else begin
            pin_meta_ff <= {target_present, near_min, ana_at_low, ana_at_high, sw1_demand,
                            sw2_demand, sw1_fault, sw2_fault, button_pressed, sync_seen};
            pin_ff <= pin_meta_ff;
        end
    end

    assign {tgt_s, near_s, low_s, high_s, dem1_s, dem2_s, flt1_s, flt2_s, btn_s, sync_s} = pin_ff;

    assign unlock = ctrl_ff[indicator_pkg::CTRL_UNLOCK];
    assign alt_mode = ctrl_ff[indicator_pkg::CTRL_ALT];
    assign setup_dis = ctrl_ff[indicator_pkg::CTRL_SETUP_DIS];
    assign role = ctrl_ff[indicator_pkg::CTRL_ROLE_LO +: 2];
    assign btn_resync = ctrl_ff[indicator_pkg::CTRL_BTN_RESYNC];

    // wishbone: one-cycle registered answer, ack dropped in the following cycle
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    // configuration writes, byte lane 0 only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= indicator_pkg::CTRL_RST;
            square_sel_ff <= indicator_pkg::SQUARE_RST;
            rect_sel_ff <= indicator_pkg::RECT_RST;
            notgt_ff <= indicator_pkg::NOTGT_RST;
        end else if (wr_en) begin
            if (wb_adr_i == indicator_pkg::CTRL_OFS) begin
                ctrl_ff <= wb_dat_i[5:0];
            end
            if (wb_adr_i == indicator_pkg::ASSIGN_OFS) begin
                square_sel_ff <= wb_dat_i[2:0];
                rect_sel_ff <= wb_dat_i[6:4];
            end
            if (wb_adr_i == indicator_pkg::NOTGT_OFS) begin
                notgt_ff <= wb_dat_i[1:0];
            end
        end
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req) begin
            unique case (wb_adr_i)
                indicator_pkg::CTRL_OFS: rdata_ff <= {26'h0, ctrl_ff};
                indicator_pkg::ASSIGN_OFS: rdata_ff <= {25'h0, rect_sel_ff, 1'b0, square_sel_ff};
                indicator_pkg::NOTGT_OFS: rdata_ff <= {30'h0, notgt_ff};
                indicator_pkg::STATUS_OFS: rdata_ff <= {20'h0, mode, notgt_timeout_ff, nosync, flt2_s,
                                                       flt1_s, sw2_ff, sw1_ff, green_ff, red_ff, tgt_s};
                indicator_pkg::SETUP_OFS: rdata_ff <= {24'h0, flash_cnt_ff, select_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // time the absence of a target
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            notgt_cnt_ff <= '0;
            notgt_timeout_ff <= 1'b0;
        end else if (tgt_s) begin
            notgt_cnt_ff <= '0;
            notgt_timeout_ff <= 1'b0;
        end else if (notgt_cnt_ff == indicator_pkg::CNT_W'(NO_TARGET - 1)) begin
            notgt_timeout_ff <= 1'b1;
        end else begin
            notgt_cnt_ff <= notgt_cnt_ff + 1'b1;
        end
    end

    // button may override the warning until sync returns
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resync_skip_ff <= 1'b0;
        end else if (sync_s) begin
            resync_skip_ff <= 1'b0;
        end else if (btn_resync && btn_s && role == indicator_pkg::ROLE_SLAVE) begin
            resync_skip_ff <= 1'b1;
        end
    end

    assign nosync = role == indicator_pkg::ROLE_SLAVE && !sync_s && !resync_skip_ff;
    // feedback suppressed when setup off and no sync role
    assign feedback_on = btn_s && !(setup_dis && role == indicator_pkg::ROLE_NONE);

    always_comb begin
        if (nosync) begin
            mode = indicator_pkg::MODE_NOSYNC;
        end else if (feedback_on) begin
            mode = indicator_pkg::MODE_BUTTON;
        end else if (unlock) begin
            mode = indicator_pkg::MODE_UNLOCK;
        end else if (tgt_s && near_s) begin
            mode = indicator_pkg::MODE_NEAR;
        end else begin
            mode = indicator_pkg::MODE_NORMAL;
        end
    end

    // every mode lights one colour or blinks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            red_ff <= 1'b1;
            green_ff <= 1'b0;
        end else begin
            unique case (mode)
                indicator_pkg::MODE_NORMAL: begin
                    red_ff <= ~tgt_s;
                    green_ff <= tgt_s;
                end
                indicator_pkg::MODE_NEAR: begin
                    red_ff <= 1'b0;
                    green_ff <= bl.fast;
                end
                indicator_pkg::MODE_UNLOCK: begin
                    red_ff <= ~tgt_s & (alt_mode ? bl.dbl : bl.slow);
                    green_ff <= tgt_s & (alt_mode ? bl.dbl : bl.slow);
                end
                indicator_pkg::MODE_BUTTON: begin
                    red_ff <= alt_mode ? bl.dbl : bl.slow;
                    green_ff <= 1'b0;
                end
                indicator_pkg::MODE_NOSYNC: begin
                    red_ff <= bl.slow;
                    green_ff <= ~bl.slow;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            btn_d_ff <= 1'b0;
            flash_cnt_ff <= 4'h0;
            select_ff <= 4'h0;
            strobe_ff <= 1'b0;
        end else begin
            btn_d_ff <= btn_s;
            strobe_ff <= 1'b0;
            if (btn_s && !btn_d_ff) begin
                flash_cnt_ff <= 4'h0;
            end else if (feedback_on && bl.slow_tick && flash_cnt_ff != 4'hF) begin
                flash_cnt_ff <= flash_cnt_ff + 4'h1;
            end
            if (!btn_s && btn_d_ff && flash_cnt_ff != 4'h0 && !(setup_dis && role == indicator_pkg::ROLE_NONE)) begin
                select_ff <= flash_cnt_ff;
                strobe_ff <= 1'b1;
            end
        end
    end

    // optional turn-off after the no-target time
    assign sw1_next = dem1_s && !flt1_s && !(notgt_ff[indicator_pkg::NOTGT_SW_OFF] && notgt_timeout_ff);
    assign sw2_next = dem2_s && !flt2_s && !(notgt_ff[indicator_pkg::NOTGT_SW_OFF] && notgt_timeout_ff);
    assign tx_any = tx_reply_event | tx_stream_event;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sw1_ff <= 1'b0;
            sw2_ff <= 1'b0;
            hold_ff <= 1'b0;
            filt_ff <= 1'b1;
            meas_ff <= 1'b1;
        end else begin
            sw1_ff <= sw1_next;
            sw2_ff <= sw2_next;
            // hold last analog value without target
            hold_ff <= ~tgt_s & notgt_ff[indicator_pkg::NOTGT_HOLD];
            filt_ff <= ~unlock;
            meas_ff <= ~nosync;
        end
    end

    blink_gen #(
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF)
    ) u_blink (
        .clock(clock),
        .rst(rst),
        .bl(bl.gen)
    );

    status_lamp #(
        .FLICKER(FLICKER)
    ) u_square (
        .clock(clock),
        .rst(rst),
        .sel(square_sel_ff),
        .ana_low(low_s),
        .ana_high(high_s),
        .sw_on(sw1_ff),
        .sw_fault(flt1_s),
        .rx_pulse(rx_event),
        .tx_pulse(tx_any),
        .bl(bl.use_side),
        .lamp(sq_next)
    );

    status_lamp #(
        .FLICKER(FLICKER)
    ) u_rect (
        .clock(clock),
        .rst(rst),
        .sel(rect_sel_ff),
        .ana_low(low_s),
        .ana_high(high_s),
        .sw_on(sw2_ff),
        .sw_fault(flt2_s),
        .rx_pulse(rx_event),
        .tx_pulse(tx_any),
        .bl(bl.use_side),
        .lamp(rect_next)
    );

    // lamps registered so outputs stay glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sq_ff <= 1'b0;
            rect_ff <= 1'b0;
        end else begin
            sq_ff <= sq_next;
            rect_ff <= rect_next;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign tgt_red = red_ff;
    assign tgt_green = green_ff;
    assign square_lamp = sq_ff;
    assign rect_lamp = rect_ff;
    assign sw1_out = sw1_ff;
    assign sw2_out = sw2_ff;
    assign analog_hold = hold_ff;
    assign filters_enable = filt_ff;
    assign measure_enable = meas_ff;
    assign setup_select = select_ff;
    assign setup_strobe = strobe_ff;
endmodule

// ===== indicator_ctrl_sva.sv
// checker for the status-indicator controller, sees top-level ports only
// assumes one clock domain with rst active high, asynchronous
`timescale 1ns/1ps
module indicator_ctrl_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // pins
    input wire logic target_present,
    input wire logic sw1_demand,
    input wire logic sw1_fault,
    input wire logic sync_seen,
    // outputs
    input wire logic tgt_red,
    input wire logic tgt_green,
    input wire logic sw1_out,
    input wire logic measure_enable,
    input wire logic [3:0] setup_select,
    input wire logic setup_strobe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_on_take: assert property (req_taken |=> ack_pulse) else $error("ack missing or too long");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_lamp_one_colour: assert property (!(tgt_red && tgt_green)) else $error("both colours lit");
    a_green_needs_target: assert property (tgt_green && measure_enable |-> $past(target_present, 3))
        else $error("green without target");
    a_switch_gated: assert property (sw1_out |-> $past(sw1_demand, 3) && !$past(sw1_fault, 3))
        else $error("switch on without demand or in fault");
    a_strobe_single: assert property (setup_strobe |-> setup_select != 4'h0 ##1 !setup_strobe)
        else $error("bad setup strobe");
    a_nosync_alternate: assert property (!measure_enable |-> tgt_red != tgt_green)
        else $error("no-sync lamp not alternating");
    a_nosync_cause: assert property (!measure_enable |-> !$past(sync_seen, 3))
        else $error("measuring stopped with sync present");
endmodule

bind indicator_ctrl indicator_ctrl_sva i_indicator_ctrl_sva (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .target_present(target_present), .sw1_demand(sw1_demand),
    .sw1_fault(sw1_fault), .sync_seen(sync_seen), .tgt_red(tgt_red), .tgt_green(tgt_green), .sw1_out(sw1_out),
    .measure_enable(measure_enable), .setup_select(setup_select), .setup_strobe(setup_strobe));

// ===== test_indicator_ctrl.sv
// self-checking bench for the status-indicator controller
// assumes short blink counts: slow half 8, fast half 2, flicker 4, no-target 50
`timescale 1ns/1ps
module test_indicator_ctrl;
    logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, tp = 0, nm = 0, lo = 0, hi = 0;
    logic d1 = 0, d2 = 0, f1 = 0, f2 = 0, btn = 0, sy = 0, rx = 0, txr = 0, txs = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q, rdat;
    logic ack, red, grn, sq, rc, s1, s2, hold, filt, meas, stbo;
    logic [3:0] sel;
    int n_errors = 0, total_checks = 0, rr, gr, sr;

    indicator_ctrl #(.NO_TARGET(50), .SLOW_HALF(8), .FAST_HALF(2), .FLICKER(4)) i_indicator_ctrl (
        .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .target_present(tp), .near_min(nm),
        .ana_at_low(lo), .ana_at_high(hi), .sw1_demand(d1), .sw2_demand(d2), .sw1_fault(f1), .sw2_fault(f2),
        .button_pressed(btn), .sync_seen(sy), .rx_event(rx), .tx_reply_event(txr), .tx_stream_event(txs),
        .tgt_red(red), .tgt_green(grn), .square_lamp(sq), .rect_lamp(rc), .sw1_out(s1), .sw2_out(s2),
        .analog_hold(hold), .filters_enable(filt), .measure_enable(meas), .setup_select(sel),
        .setup_strobe(stbo));

    initial forever #12.5 clock = ~clock;

    task chk(string what, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task cy(int n);
        repeat (n) @(posedge clock);
    endtask

    // request held until ack is sampled high
    task wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rdat = q;
        {cyc, stb} <= 2'b00;
    endtask

    // counts rising edges of red, green and square over n cycles
    task watch(int n);
        logic pr, pg, ps;
        rr = 0;
        gr = 0;
        sr = 0;
        {pr, pg, ps} = {red, grn, sq};
        repeat (n) begin
            @(negedge clock);
            rr += int'(red & !pr);
            gr += int'(grn & !pg);
            sr += int'(sq & !ps);
            {pr, pg, ps} = {red, grn, sq};
        end
        @(posedge clock);
    endtask

    task t_regs;
        wb(0, 8'h00, 0); chk("ctrl", 0, rdat);
        wb(0, 8'h04, 0); chk("assign", 32'h41, rdat);
        wb(0, 8'h08, 0); chk("notgt", 3, rdat);
        wb(1, 8'h20, 32'hFF); wb(0, 8'h20, 0); chk("unmapped", 0, rdat);
        $display("regs done");
    endtask

    task t_target;
        tp <= 1; cy(6); chk("green", 1, {red, grn});
        nm <= 1; cy(6); watch(40); chk("near_green", 10, gr); chk("near_red", 0, rr);
        nm <= 0; wb(1, 8'h00, 1); cy(4); chk("filters", 0, filt);
        watch(64); chk("unlock_blink", 4, gr); chk("unlock_red", 0, rr);
        wb(1, 8'h00, 3); cy(2); watch(64); chk("alt_unlock", 8, gr);
        wb(1, 8'h00, 0); cy(4); chk("filters_back", 1, filt);
        tp <= 0; cy(6); chk("red", 2, {red, grn});
        $display("target done");
    endtask

    task t_button;
        int n;
        n = 0;
        btn <= 1; cy(2); watch(61); chk("hold_green", 0, gr); chk("hold_blink", 1, rr >= 3);
        btn <= 0;
        while (stbo !== 1'b1 && n < 12) begin
            @(posedge clock);
            n++;
        end
        chk("strobe", 1, stbo); chk("select", 4, sel);
        wb(1, 8'h00, 4); btn <= 1; cy(4); watch(32); chk("suppressed", 0, rr); btn <= 0; cy(4);
        chk("no_strobe", 0, stbo); wb(1, 8'h00, 0);
        $display("button done");
    endtask

    task t_switch;
        wb(1, 8'h04, 32'h22); tp <= 1; d1 <= 1; cy(8); chk("sw_lamps", 3'b101, {sq, rc, s1});
        f1 <= 1; cy(6); chk("fault_off", 0, s1); watch(64); chk("fault_blink", 4, sr);
        f1 <= 0; cy(8); chk("resume", 3'b11, {sq, s1});
        tp <= 0; cy(60); chk("no_target", 3'b01, {s1, hold});
        d1 <= 0;
        $display("switch done");
    endtask

    task t_serial;
        wb(1, 8'h04, 32'h43); rx <= 1; @(posedge clock); rx <= 0; cy(2); chk("rx", 2, {sq, rc});
        cy(10); chk("rx_end", 0, sq); txs <= 1; @(posedge clock); txs <= 0; cy(3); chk("tx_stream", 1, rc);
        cy(10); txr <= 1; @(posedge clock); txr <= 0; cy(3); chk("tx_reply", 1, rc);
        $display("serial done");
    endtask

    task t_nosync;
        wb(1, 8'h00, 32'h10); cy(6); chk("measure_off", 0, meas);
        watch(32); chk("alt", 4, rr + gr);
        sy <= 1; cy(6); chk("measure_on", 1, meas); wb(1, 8'h00, 0);
        $display("nosync done");
    endtask

    task t_analog;
        wb(1, 8'h04, 32'h21); tp <= 1; d2 <= 1; cy(8); chk("analog_mid", 1, sq);
        chk("rect_sw2", 3, {rc, s2});
        lo <= 1; cy(8); chk("analog_low", 0, sq);
        lo <= 0; hi <= 1; cy(8); watch(16); chk("analog_high", 4, sr);
        wb(1, 8'h04, 32'h00); hi <= 0; d2 <= 0; cy(8); chk("lamps_off", 0, {sq, rc});
        $display("analog done");
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        cy(10);
        rst <= 0;
        t_regs(); t_target(); t_button(); t_switch(); t_serial(); t_nosync(); t_analog();
        test_done();
    end

    // whole run is about 630 cycles
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule
